//--- rtl/vbsc_pkg.sv
`default_nettype none

package vbsc_pkg;

    // register map, byte addresses on the serial configuration port
    localparam logic [7:0]  VBSC_CTRL_ADDR      = 8'h04;
    localparam logic [7:0]  VBSC_STATUS_ADDR    = 8'h09;

    // clock_multiplier_control field layout
    localparam int          VBSC_LOOPBW_MSB     = 20;
    localparam int          VBSC_LOOPBW_LSB     = 16;
    localparam int          VBSC_PLL_EN_BIT     = 15;
    localparam int          VBSC_RATIO1_MSB     = 14;
    localparam int          VBSC_RATIO1_LSB     = 13;
    localparam int          VBSC_RATIO2_MSB     = 12;
    localparam int          VBSC_RATIO2_LSB     = 11;
    localparam int          VBSC_BIAS_MSB       = 10;
    localparam int          VBSC_BIAS_LSB       = 8;
    localparam int          VBSC_BAND_MSB       = 7;
    localparam int          VBSC_BAND_LSB       = 2;
    localparam int          VBSC_DRIVE_MSB      = 1;
    localparam int          VBSC_DRIVE_LSB      = 0;
    localparam logic [31:0] VBSC_CTRL_RESET     = 32'h0000_0000;
    localparam logic [31:0] VBSC_CTRL_WMASK     = 32'h001F_FFFF;

    // lock_status field layout
    localparam int          VBSC_LOCK_BIT       = 3;

    // band codes
    localparam logic [5:0]  VBSC_BAND_AUTO      = 6'h3F;
    localparam logic [5:0]  VBSC_BAND_MIN       = 6'h00;
    localparam logic [5:0]  VBSC_BAND_MAX_FIXED = 6'h3E;

    // timing
    localparam int          VBSC_CLK_FREQ_KHZ   = 10000;
    localparam int          VBSC_LOCK_TIME_US   = 5000;
    localparam int          VBSC_LOCK_CYCLES    = VBSC_LOCK_TIME_US * VBSC_CLK_FREQ_KHZ / 1000;
    localparam int          VBSC_DWELL_TIME_US  = 500;
    localparam int          VBSC_DWELL_CYCLES   = VBSC_DWELL_TIME_US * VBSC_CLK_FREQ_KHZ / 1000;

    typedef enum logic [1:0] {
        VBSC_IDLE   = 2'b00,
        VBSC_SETTLE = 2'b01,
        VBSC_DECIDE = 2'b11,
        VBSC_DONE   = 2'b10
    } vbsc_state_type;

    function automatic logic [5:0] vbsc_midpoint(input logic [5:0] lo, input logic [5:0] hi);
        logic [6:0] sum;
        sum = {1'b0, lo} + {1'b0, hi};
        return sum[6:1];
    endfunction

endpackage

`default_nettype wire

//--- rtl/vbsc_band_search.sv
`default_nettype none

module vbsc_band_search
    import vbsc_pkg::*;
#(
    parameter int DWELL_CYCLES = VBSC_DWELL_CYCLES
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic       abort,
    input  wire logic       reference_clock_input_ok,
    input  wire logic       vco_below_target,
    output logic [5:0]      band,
    output logic            busy,
    output logic            done
);

    vbsc_state_type state_reg, state_next;
    logic [5:0]     lo_reg, lo_next;
    logic [5:0]     hi_reg, hi_next;
    logic [5:0]     band_reg, band_next;
    logic [31:0]    timer_reg, timer_next;
    logic [5:0]     lo_new;
    logic [5:0]     hi_new;

    always_comb begin
        state_next = state_reg;
        lo_next    = lo_reg;
        hi_next    = hi_reg;
        band_next  = band_reg;
        timer_next = timer_reg;
        lo_new     = lo_reg;
        hi_new     = hi_reg;
        if (start) begin
            // binary search over the fixed bands only, the auto code is never tried
            lo_next    = VBSC_BAND_MIN;
            hi_next    = VBSC_BAND_MAX_FIXED;
            band_next  = vbsc_midpoint(VBSC_BAND_MIN, VBSC_BAND_MAX_FIXED);
            timer_next = 32'h0000_0000;
            state_next = VBSC_SETTLE;
        end else if (abort) begin
            state_next = VBSC_IDLE;
        end else begin
            case (state_reg)
                VBSC_IDLE: begin
                    state_next = VBSC_IDLE;
                end
                VBSC_SETTLE: begin
                    // a missing reference clock freezes the dwell instead of misjudging
                    if (reference_clock_input_ok) begin
                        if (timer_reg == 32'(DWELL_CYCLES - 1)) begin
                            state_next = VBSC_DECIDE;
                        end else begin
                            timer_next = timer_reg + 32'h0000_0001;
                        end
                    end
                end
                VBSC_DECIDE: begin
                    // higher codes run faster, so a slow vco moves the window up
                    if (vco_below_target) begin
                        lo_new = band_reg + 6'h01;
                    end else begin
                        hi_new = band_reg;
                    end
                    lo_next    = lo_new;
                    hi_next    = hi_new;
                    timer_next = 32'h0000_0000;
                    if (lo_new == hi_new) begin
                        band_next  = lo_new;
                        state_next = VBSC_DONE;
                    end else begin
                        band_next  = vbsc_midpoint(lo_new, hi_new);
                        state_next = VBSC_SETTLE;
                    end
                end
                VBSC_DONE: begin
                    state_next = VBSC_DONE;
                end
                default: begin
                    state_next = VBSC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= VBSC_IDLE;
            lo_reg    <= VBSC_BAND_MIN;
            hi_reg    <= VBSC_BAND_MAX_FIXED;
            band_reg  <= VBSC_BAND_MIN;
            timer_reg <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            lo_reg    <= lo_next;
            hi_reg    <= hi_next;
            band_reg  <= band_next;
            timer_reg <= timer_next;
        end
    end

    assign band = band_reg;
    assign busy = (state_reg == VBSC_SETTLE) || (state_reg == VBSC_DECIDE);
    assign done = (state_reg == VBSC_DONE);

endmodule // vbsc_band_search

`default_nettype wire

//--- rtl/vbsc_band_select.sv
// Overview of operation
// - band field bits 7:2; 63 starts search
// - codes 0..62 fix one band, rising frequency
// - auto search ends with lock pin, bit 3
// - after lock, band field reads chosen band
// - writing 0..62 fixes band, leaves auto
`default_nettype none

module vbsc_band_select
    import vbsc_pkg::*;
#(
    parameter int DWELL_CYCLES = VBSC_DWELL_CYCLES,
    parameter int LOCK_CYCLES  = VBSC_LOCK_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic [31:0]      reg_rdata,
    input  wire logic        reference_clock_input_ok,
    input  wire logic        vco_below_target,
    input  wire logic        pll_phase_locked,
    output logic             lock_pin,
    output logic [5:0]       osc_band,
    output logic             pll_enable,
    output logic [1:0]       vco_ratio_first,
    output logic [1:0]       clock_ratio_second,
    output logic [4:0]       loop_bandwidth,
    output logic [2:0]       pll_bias,
    output logic [1:0]       vco_drive
);

    logic [31:0] ctrl_reg, ctrl_next;
    logic        auto_reg, auto_next;
    logic        lock_reg, lock_next;
    logic [5:0]  osc_band_reg, osc_band_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        ctrl_wr;
    logic [5:0]  wr_band;
    logic        search_start;
    logic        search_abort;
    logic [5:0]  search_band;
    logic        search_busy;
    logic        search_done;
    logic [5:0]  band_readback;
    logic [31:0] search_cycles_reg, search_cycles_next;

    assign ctrl_wr      = reg_wr && (reg_addr == VBSC_CTRL_ADDR);
    assign wr_band      = reg_wdata[VBSC_BAND_MSB:VBSC_BAND_LSB];
    assign search_start = ctrl_wr && (wr_band == VBSC_BAND_AUTO);
    assign search_abort = ctrl_wr && (wr_band != VBSC_BAND_AUTO);

    vbsc_band_search #(
        .DWELL_CYCLES     (DWELL_CYCLES)
    ) u_search (
        .clock            (clock),
        .rst              (rst),
        .start            (search_start),
        .abort            (search_abort),
        .reference_clock_input_ok        (reference_clock_input_ok),
        .vco_below_target (vco_below_target),
        .band             (search_band),
        .busy             (search_busy),
        .done             (search_done)
    );

    // an unfinished search reads back the auto code, never a trial band
    always_comb begin
        if (auto_reg && search_done) begin
            band_readback = search_band;
        end else if (auto_reg) begin
            band_readback = VBSC_BAND_AUTO;
        end else begin
            band_readback = ctrl_reg[VBSC_BAND_MSB:VBSC_BAND_LSB];
        end
    end

    always_comb begin
        ctrl_next     = ctrl_reg;
        auto_next     = auto_reg;
        lock_next     = lock_reg;
        osc_band_next = osc_band_reg;
        rdata_next    = 32'h0000_0000;
        // ratios and bias are plain storage; the host loads them before a search
        if (ctrl_wr) begin
            ctrl_next = reg_wdata & VBSC_CTRL_WMASK;
            auto_next = (wr_band == VBSC_BAND_AUTO);
        end
        if (auto_reg) begin
            osc_band_next = search_band;
        end else begin
            osc_band_next = ctrl_reg[VBSC_BAND_MSB:VBSC_BAND_LSB];
        end
        // any band change drops lock for at least one cycle
        if (ctrl_wr) begin
            lock_next = 1'b0;
        end else if (auto_reg) begin
            lock_next = search_done;
        end else begin
            lock_next = ctrl_reg[VBSC_PLL_EN_BIT] && pll_phase_locked;
        end
        if (reg_rd) begin
            case (reg_addr)
                VBSC_CTRL_ADDR: begin
                    rdata_next = ctrl_reg;
                    rdata_next[VBSC_BAND_MSB:VBSC_BAND_LSB] = band_readback;
                end
                VBSC_STATUS_ADDR: begin
                    rdata_next[VBSC_LOCK_BIT] = lock_reg;
                end
                default: begin
                    rdata_next = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_reg     <= VBSC_CTRL_RESET;
            auto_reg     <= 1'b0;
            lock_reg     <= 1'b0;
            osc_band_reg <= VBSC_BAND_MIN;
            rdata_reg    <= 32'h0000_0000;
        end else begin
            ctrl_reg     <= ctrl_next;
            auto_reg     <= auto_next;
            lock_reg     <= lock_next;
            osc_band_reg <= osc_band_next;
            rdata_reg    <= rdata_next;
        end
    end

    assign reg_rdata          = rdata_reg;
    assign lock_pin           = lock_reg;
    assign osc_band           = osc_band_reg;
    assign pll_enable         = ctrl_reg[VBSC_PLL_EN_BIT];
    assign vco_ratio_first    = ctrl_reg[VBSC_RATIO1_MSB:VBSC_RATIO1_LSB];
    assign clock_ratio_second = ctrl_reg[VBSC_RATIO2_MSB:VBSC_RATIO2_LSB];
    assign loop_bandwidth     = ctrl_reg[VBSC_LOOPBW_MSB:VBSC_LOOPBW_LSB];
    assign pll_bias           = ctrl_reg[VBSC_BIAS_MSB:VBSC_BIAS_LSB];
    assign vco_drive          = ctrl_reg[VBSC_DRIVE_MSB:VBSC_DRIVE_LSB];

    // cycles spent searching with the reference present, for the lock deadline
    always_comb begin
        search_cycles_next = search_cycles_reg;
        if (!search_busy) begin
            search_cycles_next = 32'h0000_0000;
        end else if (reference_clock_input_ok) begin
            search_cycles_next = search_cycles_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            search_cycles_reg <= 32'h0000_0000;
        end else begin
            search_cycles_reg <= search_cycles_next;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence fixed_write_s;
        ctrl_wr && (wr_band != VBSC_BAND_AUTO) ##1 !ctrl_wr;
    endsequence

    sequence auto_write_s;
        ctrl_wr && (wr_band == VBSC_BAND_AUTO);
    endsequence

    auto_mode_entry_a: assert property (auto_write_s |=> auto_reg && search_busy)
        else $error("band code 63 did not start the search");

    fixed_band_apply_a: assert property (
        fixed_write_s |-> ##1
        (!auto_reg && osc_band == $past(reg_wdata[VBSC_BAND_MSB:VBSC_BAND_LSB], 2)))
        else $error("fixed band not applied to oscillator");

    search_lock_low_a: assert property (search_busy |-> !lock_pin && !search_done)
        else $error("lock seen while search still running");

    lock_after_search_a: assert property (
        auto_reg && search_done && !ctrl_wr |=> lock_pin)
        else $error("lock not raised after search finished");

    lock_deadline_a: assert property (search_cycles_reg < 32'(LOCK_CYCLES))
        else $error("search exceeded the lock deadline");

    band_readback_a: assert property (
        reg_rd && reg_addr == VBSC_CTRL_ADDR && auto_reg && search_done
        |=> reg_rdata[VBSC_BAND_MSB:VBSC_BAND_LSB] == $past(search_band))
        else $error("readback differs from the chosen band");

    pending_readback_a: assert property (
        reg_rd && reg_addr == VBSC_CTRL_ADDR && auto_reg && !search_done
        |=> reg_rdata[7:2] == VBSC_BAND_AUTO)
        else $error("unfinished search read back a trial band");

    status_lock_a: assert property (
        reg_rd && reg_addr == VBSC_STATUS_ADDR |=> reg_rdata[VBSC_LOCK_BIT] == $past(lock_pin))
        else $error("status lock bit differs from lock pin");

    search_range_a: assert property (search_done |-> search_band <= VBSC_BAND_MAX_FIXED)
        else $error("search chose a band outside the fixed range");

    fixed_lock_follow_a: assert property (
        !auto_reg && !ctrl_wr |=> lock_pin == $past(pll_enable && pll_phase_locked))
        else $error("fixed-band lock does not follow the loop lock");

    osc_band_range_a: assert property (osc_band <= VBSC_BAND_MAX_FIXED)
        else $error("oscillator driven with the auto code");

endmodule // vbsc_band_select

`default_nettype wire

//--- verif/vbsc_host_model.sv
`default_nettype none

module vbsc_host_model
    import vbsc_pkg::*;
(
    input  wire logic        clock,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic [7:0]       reg_addr,
    output logic [31:0]      reg_wdata,
    input  wire logic [31:0] reg_rdata,
    input  wire logic        lock_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [5:0] nv_band;

    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0000_0000;
        nv_band   = 6'h00;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge clock);
        #1;
        reg_wr    = 1'b0;
        reg_wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        #1;
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge clock);
        #1;
        d      = reg_rdata;
        reg_rd = 1'b0;
    endtask

    // ratios and bias travel in every control word, so they are set before any search
    function automatic logic [31:0] ctrl_word(input logic [5:0] band);
        return {11'h000, 5'h0F, 1'h1, 2'h1, 2'h2, 3'h3, band, 2'h3};
    endfunction

    // no readback is trusted before lock shows on the pin
    task automatic wait_lock(input int limit, output logic ok);
        ok = 1'b0;
        for (int n = 0; n < limit && !ok; n++) begin
            @(posedge clock);
            #1;
            ok = lock_pin;
        end
    endtask

    // t counts start-up temperature ranges from coldest; lower bands lack the +3 step
    function automatic logic [5:0] temp_band(input logic [5:0] rb, input int t);
        int nb;
        nb = int'(rb) + ((rb >= 6'h20) ? 3 - t : 2 - t);
        if (nb > 62) nb = 62;
        if (nb < 0) nb = 0;
        return nb[5:0];
    endfunction

    task automatic store_factory(input logic [5:0] b);
        nv_band = b;
    endtask

    task automatic reload();
        wr(VBSC_CTRL_ADDR, ctrl_word(nv_band));
    endtask
endmodule // vbsc_host_model

`default_nettype wire

//--- verif/tb_vbsc_band_select.sv
`default_nettype none

module tb_vbsc_band_select
    import vbsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clock, rst, reg_wr, reg_rd, reference_clock_input_ok, vco_below_target, pll_phase_locked;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d, w;
    logic        lock_pin, pll_enable, ok;
    logic [5:0]  osc_band, target, rb, nb;
    logic [1:0]  vco_ratio_first, clock_ratio_second, vco_drive;
    logic [4:0]  loop_bandwidth;
    logic [2:0]  pll_bias;
    int          error_cnt, n_compared, cyc, t;
    int          exp_q[$];

    vbsc_band_select #(.DWELL_CYCLES(4), .LOCK_CYCLES(64)) dut (
        .clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reference_clock_input_ok(reference_clock_input_ok),
        .vco_below_target(vco_below_target), .pll_phase_locked(pll_phase_locked),
        .lock_pin(lock_pin), .osc_band(osc_band), .pll_enable(pll_enable),
        .vco_ratio_first(vco_ratio_first), .clock_ratio_second(clock_ratio_second),
        .loop_bandwidth(loop_bandwidth), .pll_bias(pll_bias), .vco_drive(vco_drive));

    vbsc_host_model h (
        .clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .lock_pin(lock_pin));

    initial clock = 1'b0;
    always #50 clock = ~clock;

    // oscillator model: too slow whenever the trial band sits below the target band
    always @(posedge clock) #1 vco_below_target = (osc_band < target);

    always @(posedge clock) begin
        cyc++;
        if (cyc == 6000) begin
            error_cnt++;
            final_report();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        reference_clock_input_ok = 1'b1;
        pll_phase_locked = 1'b0;
        vco_below_target = 1'b0;
        target = 6'h00;
        d = $urandom(20912);
        repeat (20) @(posedge clock);
        #1;
        rst = 1'b0;
        h.rd(VBSC_CTRL_ADDR, d);
        check(d, VBSC_CTRL_RESET);
        h.rd(VBSC_STATUS_ADDR, d);
        check(d, 32'h0000_0000);
        // upper junk must be dropped, every field must reach its output
        w = h.ctrl_word(6'h2A) | 32'hFFE0_0000;
        h.wr(VBSC_CTRL_ADDR, w);
        @(posedge clock);
        #1;
        check({11'h000, loop_bandwidth, pll_enable, vco_ratio_first, clock_ratio_second,
               pll_bias, osc_band, vco_drive}, w & VBSC_CTRL_WMASK);
        pll_phase_locked = 1'b1;
        h.rd(VBSC_CTRL_ADDR, d);
        check(d, w & VBSC_CTRL_WMASK);
        check({31'h0, lock_pin}, 32'h0000_0001);
        h.wr(VBSC_STATUS_ADDR, 32'hFFFF_FFFF);
        h.rd(8'h33, d);
        check(d, 32'h0000_0000);
        h.rd(VBSC_STATUS_ADDR, d);
        check(d, 32'h0000_0008);
        // read data stands one cycle only
        @(posedge clock);
        #1;
        check(reg_rdata, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            target = (i == 0) ? 6'h00 : (i == 1) ? 6'h3E : 6'($urandom_range(62, 0));
            h.wr(VBSC_CTRL_ADDR, h.ctrl_word(VBSC_BAND_AUTO));
            // the lowest band that is not too slow is the one the search must settle on
            exp_q.push_back(int'(target));
            h.rd(VBSC_CTRL_ADDR, d);
            check({25'h0, d[7:2], lock_pin}, {25'h0, VBSC_BAND_AUTO, 1'b0});
            if (i == 2) begin
                // a missing reference clock must freeze the search, never fake a lock
                reference_clock_input_ok = 1'b0;
                repeat (40) @(posedge clock);
                #1;
                check({31'h0, lock_pin}, 32'h0000_0000);
                reference_clock_input_ok = 1'b1;
            end
            h.wait_lock(64, ok);
            #1;
            check({31'h0, ok}, 32'h0000_0001);
            check({26'h0, osc_band}, {26'h0, target});
            h.rd(VBSC_CTRL_ADDR, d);
            rb = d[7:2];
            check({26'h0, rb}, 32'(exp_q.pop_front()));
            h.rd(VBSC_STATUS_ADDR, d);
            check(d, 32'h0000_0008);
            if (i == 1) h.store_factory(rb);
            t = (rb >= 6'h20) ? $urandom_range(4, 0) : $urandom_range(3, 0);
            nb = h.temp_band(rb, t);
            pll_phase_locked = 1'($urandom_range(1, 0));
            h.wr(VBSC_CTRL_ADDR, h.ctrl_word(nb));
            @(posedge clock);
            #1;
            check({26'h0, osc_band}, {26'h0, nb});
            repeat (2) @(posedge clock);
            #1;
            check({31'h0, lock_pin}, {31'h0, pll_phase_locked});
        end
        h.reload();
        @(posedge clock);
        #1;
        check({26'h0, osc_band}, {26'h0, VBSC_BAND_MAX_FIXED});
        h.rd(VBSC_CTRL_ADDR, d);
        check({26'h0, d[7:2]}, {26'h0, VBSC_BAND_MAX_FIXED});
        final_report();
    end
endmodule // tb_vbsc_band_select

`default_nettype wire
